// ===== rtl/pprl_lock.sv
// Purpose: Unlock sequence detector and lock flag with one-shot option
// Assumes: Any reset (power-on or other) clears the flag and one-shot history
// Notes: A flag write outside the armed state is ignored
`timescale 1ns/100ps
`default_nettype none
module pprl_lock (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic dev_rst_n,
  // Core side
  pprl_lock_if.unit lk
);

  pprl_pkg::pprl_seq_e seq_q, seq_d;
  logic locked_q;
  logic cleared_q;
  logic set_again_q;
  logic new_flag;
  logic flag_wr;
  logic clr_ok;
  logic set_ok;
  logic do_clr;
  logic do_set;

  // Sequence decode
  assign new_flag = lk.wr_data[pprl_pkg::LOCK_BIT];
  assign flag_wr = lk.wr_stb && lk.wr_is_lock && (seq_q == pprl_pkg::SEQ_ARMED);
  assign clr_ok = !lk.fuse || (!cleared_q && !set_again_q);
  assign set_ok = !lk.fuse || !set_again_q;
  assign do_clr = flag_wr && !new_flag && locked_q && clr_ok;
  assign do_set = flag_wr && new_flag && !locked_q && set_ok;
  assign lk.locked = locked_q;

  // Next sequence state
  always_comb begin
    seq_d = seq_q;
    if (lk.wr_stb) begin
      unique case (seq_q)
        pprl_pkg::SEQ_IDLE: begin
          seq_d = (lk.wr_is_lock && lk.wr_data == pprl_pkg::KEY_FIRST) ?
                  pprl_pkg::SEQ_KEY1 : pprl_pkg::SEQ_IDLE;
        end
        pprl_pkg::SEQ_KEY1: begin
          seq_d = (lk.wr_is_lock && lk.wr_data == pprl_pkg::KEY_SECOND) ?
                  pprl_pkg::SEQ_ARMED : pprl_pkg::SEQ_IDLE;
        end
        pprl_pkg::SEQ_ARMED: begin
          seq_d = pprl_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Flag and one-shot history
  always_ff @(posedge mclk) begin
    if (!nrst || !dev_rst_n) begin
      seq_q <= pprl_pkg::SEQ_IDLE;
      locked_q <= 1'b0;
      cleared_q <= 1'b0;
      set_again_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      if (do_clr) begin
        locked_q <= 1'b0;
        cleared_q <= 1'b1;
      end else if (do_set) begin
        locked_q <= 1'b1;
        set_again_q <= 1'b1;
      end
    end
  end

endmodule : pprl_lock
`default_nettype wire

// ===== rtl/pprl_lock_if.sv
// Purpose: Carrier between the routing core and the lock sequencer
// Assumes: Single clock domain
// Notes: wr_stb is a one-cycle pulse for any register write
`timescale 1ns/100ps
`default_nettype none
interface pprl_lock_if;
  logic wr_stb;
  logic wr_is_lock;
  logic [pprl_pkg::DATA_W-1:0] wr_data;
  logic fuse;
  logic locked;

  modport core (output wr_stb, output wr_is_lock, output wr_data, output fuse, input locked);
  modport unit (input wr_stb, input wr_is_lock, input wr_data, input fuse, output locked);
endinterface : pprl_lock_if
`default_nettype wire

// ===== rtl/pprl_pkg.sv
// Purpose: Shared constants for the peripheral pin routing and lock block
// Assumes: One 25 MHz clock (mclk), all inputs synchronous to it
// Notes: Selector codes are common to every peripheral input and every pin
//
// Overview of operation
// - Each peripheral input has its own selector choosing its source pin.
// - Several peripheral inputs may select one pin and all see its level.
// - Port level reads always return the real pin level.
// - Only digital signals are routed; analog functions stay on their pins.
// - All input selectors share one layout and one source encoding.
// - Each pin has its own output selector, independent of input selection.
// - Pin direction control keeps enabling the driver whatever output is chosen.
// - Sync serial, I2C and waveform shutdown may override the driver enable.
// - All pin output selectors share one layout and one encoding.
// - While locked, writes to every selector are ignored.
// - Lock flag changes only after writes 0x55, 0xAA, then the flag write.
// - With the one-shot fuse, the flag sets once per reset and never clears.
// - With the fuse, once set again the flag stays set until reset.
// - Power-on reset restores selector defaults; other resets keep them.
// - Sleep entry or exit never changes any selector value.
package pprl_pkg;

  // Sizes
  localparam int N_PIN = 8;
  localparam int N_PERIN = 8;
  localparam int N_PEROUT = 8;
  localparam int SEL_W = 5;
  localparam int IDX_W = 3;
  localparam int DATA_W = 8;

  // Register kinds on the write and read ports
  localparam logic [1:0] RK_IN_SEL = 2'h0;
  localparam logic [1:0] RK_OUT_SEL = 2'h1;
  localparam logic [1:0] RK_LOCK = 2'h2;

  // Lock control register keys and field
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam int LOCK_BIT = 0;

  // Output selector code 0 picks the port data latch, code k+1 peripheral output k
  localparam logic [SEL_W-1:0] OUT_SEL_LATCH = 5'h00;
  localparam logic [SEL_W-1:0] OUT_SEL_RST = 5'h00;

  // Default input selections after power-on reset, one pin code per input
  localparam logic [N_PERIN*SEL_W-1:0] IN_SEL_RST =
    {5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};

  // Peripheral outputs allowed to take over the pin driver enable
  localparam logic [N_PEROUT-1:0] OVR_CAPABLE = 8'h07;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_KEY1, SEQ_ARMED} pprl_seq_e;

endpackage : pprl_pkg

// ===== rtl/pprl_top.sv
// Purpose: Routes peripheral inputs from pins and peripheral outputs to pins
// Assumes: nrst is the power-on reset; dev_rst_n covers every other reset
// Notes: Outputs are registered, so routed signals lag their sources by one cycle
`timescale 1ns/100ps
`default_nettype none
module pprl_top (
  // Clock and resets
  input wire logic mclk,
  input wire logic nrst,
  input wire logic dev_rst_n,
  // Register write port
  input wire logic reg_wr,
  input wire logic [1:0] reg_wr_kind,
  input wire logic [pprl_pkg::IDX_W-1:0] reg_wr_idx,
  input wire logic [pprl_pkg::DATA_W-1:0] reg_wr_data,
  // Register read port
  input wire logic [1:0] reg_rd_kind,
  input wire logic [pprl_pkg::IDX_W-1:0] reg_rd_idx,
  output logic [pprl_pkg::DATA_W-1:0] reg_rd_data_q,
  // Configuration and status
  input wire logic one_shot_lock_fuse,
  input wire logic sleep_mode,
  output logic selection_lock_flag_q,
  // Port controls
  input wire logic [pprl_pkg::N_PIN-1:0] pin_direction_control,
  input wire logic [pprl_pkg::N_PIN-1:0] port_latch,
  input wire logic [pprl_pkg::N_PIN-1:0] analog_select,
  output logic [pprl_pkg::N_PIN-1:0] port_level_q,
  // Device pins
  input wire logic [pprl_pkg::N_PIN-1:0] pin_in,
  output logic [pprl_pkg::N_PIN-1:0] pin_out_q,
  output logic [pprl_pkg::N_PIN-1:0] pin_oe_q,
  // Peripheral side
  output logic [pprl_pkg::N_PERIN-1:0] periph_in_q,
  input wire logic [pprl_pkg::N_PEROUT-1:0] periph_out,
  input wire logic [pprl_pkg::N_PEROUT-1:0] periph_oe_req,
  input wire logic [pprl_pkg::N_PEROUT-1:0] periph_oe
);

  localparam int SW = pprl_pkg::SEL_W;

  pprl_lock_if lk ();

  logic [SW-1:0] in_sel_q [pprl_pkg::N_PERIN];
  logic [SW-1:0] out_sel_q [pprl_pkg::N_PIN];
  logic [pprl_pkg::N_PIN-1:0] pin_digital;
  logic sel_wr_ok;
  logic [pprl_pkg::DATA_W-1:0] rd_mux;
  logic sleep_unused;

  // Lock sequencer hookup
  assign lk.wr_stb = reg_wr;
  assign lk.wr_is_lock = (reg_wr_kind == pprl_pkg::RK_LOCK);
  assign lk.wr_data = reg_wr_data;
  assign lk.fuse = one_shot_lock_fuse;

  pprl_lock u_lock (
    .mclk(mclk),
    .nrst(nrst),
    .dev_rst_n(dev_rst_n),
    .lk(lk)
  );

  // Selector writes pass only while unlocked
  assign sel_wr_ok = reg_wr && !lk.locked;
  // Sleep has no path into the selectors
  assign sleep_unused = sleep_mode;
  // Analog pins keep their digital buffer off, so routed inputs read low
  assign pin_digital = pin_in & ~analog_select;

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral input selection

  genvar gi;
  generate
    for (gi = 0; gi < pprl_pkg::N_PERIN; gi++) begin : g_in
      logic wr_this;
      logic code_ok;
      logic routed;
      assign wr_this = sel_wr_ok && reg_wr_kind == pprl_pkg::RK_IN_SEL &&
                       reg_wr_idx == pprl_pkg::IDX_W'(gi);
      // Same code space for every input; codes past the last pin give low
      assign code_ok = in_sel_q[gi] < SW'(pprl_pkg::N_PIN);
      assign routed = code_ok ? pin_digital[in_sel_q[gi][pprl_pkg::IDX_W-1:0]] : 1'b0;

      // Selector holds through every reset but power-on
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          in_sel_q[gi] <= pprl_pkg::IN_SEL_RST[gi*SW +: SW];
        end else if (wr_this) begin
          in_sel_q[gi] <= reg_wr_data[SW-1:0];
        end
      end

      // Routed level to the peripheral
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          periph_in_q[gi] <= 1'b0;
        end else begin
          periph_in_q[gi] <= routed;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin output selection

  genvar gp;
  generate
    for (gp = 0; gp < pprl_pkg::N_PIN; gp++) begin : g_pin
      logic wr_this;
      logic is_periph;
      logic [SW-1:0] pidx;
      logic src_ok;
      logic data_sel;
      logic ovr;
      logic oe_sel;
      assign wr_this = sel_wr_ok && reg_wr_kind == pprl_pkg::RK_OUT_SEL &&
                       reg_wr_idx == pprl_pkg::IDX_W'(gp);
      // Code 0 is the latch, code k+1 is peripheral output k, same for all pins
      assign is_periph = out_sel_q[gp] != pprl_pkg::OUT_SEL_LATCH;
      assign pidx = out_sel_q[gp] - SW'(1);
      assign src_ok = is_periph && pidx < SW'(pprl_pkg::N_PEROUT);
      assign data_sel = !is_periph ? port_latch[gp] :
                        src_ok ? periph_out[pidx[pprl_pkg::IDX_W-1:0]] : 1'b0;
      // Only listed peripherals may take over the driver enable
      assign ovr = src_ok && pprl_pkg::OVR_CAPABLE[pidx[pprl_pkg::IDX_W-1:0]] &&
                   periph_oe_req[pidx[pprl_pkg::IDX_W-1:0]];
      assign oe_sel = ovr ? periph_oe[pidx[pprl_pkg::IDX_W-1:0]] :
                      !pin_direction_control[gp];

      // Selector holds through every reset but power-on
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          out_sel_q[gp] <= pprl_pkg::OUT_SEL_RST;
        end else if (wr_this) begin
          out_sel_q[gp] <= reg_wr_data[SW-1:0];
        end
      end

      // Registered pin drive
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          pin_out_q[gp] <= 1'b0;
          pin_oe_q[gp] <= 1'b0;
        end else begin
          pin_out_q[gp] <= data_sel;
          pin_oe_q[gp] <= oe_sel;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read side

  // Read decode; bits above the selector field read as zero
  assign rd_mux = (reg_rd_kind == pprl_pkg::RK_IN_SEL) ?
                    {3'h0, in_sel_q[reg_rd_idx]} :
                  (reg_rd_kind == pprl_pkg::RK_OUT_SEL) ?
                    {3'h0, out_sel_q[reg_rd_idx]} :
                  (reg_rd_kind == pprl_pkg::RK_LOCK) ?
                    {7'h00, lk.locked} : 8'h00;

  // Read data, pin levels and lock status
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rd_data_q <= 8'h00;
      port_level_q <= 8'h00;
      selection_lock_flag_q <= 1'b0;
    end else begin
      reg_rd_data_q <= rd_mux;
      port_level_q <= pin_in;
      selection_lock_flag_q <= lk.locked;
    end
  end

endmodule : pprl_top
`default_nettype wire

// ===== tb/pprl_far_model.sv
// Purpose: Pins and peripheral outputs on the far side
// Assumes: Levels change just after each rising edge
// Notes: Patterns move every cycle so stale values never match
`timescale 1ns/100ps
`default_nettype none
module pprl_far_model (
  // Clock
  input wire logic mclk,
  // Pin and peripheral drive
  output logic [7:0] pin_in,
  output logic [7:0] periph_out
);
  // Stepping pin levels and a twisted ring on peripheral outputs
  initial pin_in = 8'h00;
  initial periph_out = 8'hff;
  always @(posedge mclk) begin
    pin_in <= pin_in + 8'h35;
    periph_out <= {periph_out[6:0], ~periph_out[7]};
  end
endmodule : pprl_far_model
`default_nettype wire

// ===== tb/pprl_top_chk.sv
// Purpose: Port-level assertions for the routing and lock block
// Assumes: nrst is the power-on reset, dev_rst_n any other reset
// Notes: Bound to pprl_top at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module pprl_chk (
  // Clock and resets
  input wire logic mclk,
  input wire logic nrst,
  input wire logic dev_rst_n,
  // Watched ports
  input wire logic reg_wr,
  input wire logic [1:0] reg_wr_kind,
  input wire logic [7:0] reg_wr_data,
  input wire logic [1:0] reg_rd_kind,
  input wire logic [7:0] reg_rd_data_q,
  input wire logic one_shot_lock_fuse,
  input wire logic selection_lock_flag_q,
  input wire logic [7:0] pin_direction_control,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] port_level_q,
  input wire logic [7:0] pin_out_q,
  input wire logic [7:0] pin_oe_q,
  input wire logic [7:0] periph_in_q,
  input wire logic [7:0] periph_oe_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic seen_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Remembers a lock set since the last reset
  always_ff @(posedge mclk) begin
    if (!nrst || !dev_rst_n) seen_q <= 1'b0;
    else if ($rose(selection_lock_flag_q)) seen_q <= 1'b1;
  end
  flag_change_a: assert property ($changed(selection_lock_flag_q) && $past(dev_rst_n)
    && $past(dev_rst_n, 2) |-> $past(reg_wr, 2) && $past(reg_wr_kind, 2) == 2'h2
    && $past(reg_wr_data[0], 2) == selection_lock_flag_q) else $error("lock flag moved alone");
  port_level_a: assert property ($past(nrst) |-> port_level_q == $past(pin_in))
    else $error("port level differs from pin");
  oe_dir_a: assert property ($past(nrst) && $past(periph_oe_req) == 8'h00
    |-> pin_oe_q == ~$past(pin_direction_control)) else $error("driver enable wrong");
  rd_lock_a: assert property ($past(nrst) && $past(reg_rd_kind) == 2'h2
    |-> reg_rd_data_q == {7'h00, selection_lock_flag_q}) else $error("lock read wrong");
  rd_spare_a: assert property ($past(nrst) && $past(reg_rd_kind) == 2'h3
    |-> reg_rd_data_q == 8'h00) else $error("spare read not zero");
  rd_sel_a: assert property ($past(nrst) && !$past(reg_rd_kind[1])
    |-> reg_rd_data_q[7:5] == 3'h0) else $error("selector upper bits set");
  fuse_once_a: assert property (one_shot_lock_fuse && seen_q
    |-> !$rose(selection_lock_flag_q)) else $error("one-shot lock set twice");
  fuse_hold_a: assert property ($fell(selection_lock_flag_q) && $past(one_shot_lock_fuse, 2)
    |-> !$past(dev_rst_n, 2)) else $error("one-shot lock cleared");
  por_clear_a: assert property (!$past(nrst) |-> pin_out_q == 8'h00 && pin_oe_q == 8'h00
    && periph_in_q == 8'h00 && !selection_lock_flag_q) else $error("reset values wrong");
  cover property ($rose(selection_lock_flag_q));
  cover property ($fell(selection_lock_flag_q));
  cover property (reg_wr && reg_wr_kind == 2'h0 && selection_lock_flag_q);
endmodule : pprl_chk
bind pprl_top pprl_chk chk (.mclk, .nrst, .dev_rst_n, .reg_wr, .reg_wr_kind, .reg_wr_data,
  .reg_rd_kind, .reg_rd_data_q, .one_shot_lock_fuse, .selection_lock_flag_q,
  .pin_direction_control, .pin_in, .port_level_q, .pin_out_q, .pin_oe_q, .periph_in_q,
  .periph_oe_req);
`default_nettype wire

// ===== tb/test_pprl_top.sv
// Purpose: Self-checking bench for the routing and lock block
// Assumes: Far side driven by pprl_far_model
// Notes: Writes go back to back; strobe drops in idle
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module test_pprl_top;
  logic mclk, nrst, dev_rst_n, reg_wr, one_shot_lock_fuse, sleep_mode, selection_lock_flag_q;
  logic [1:0] reg_wr_kind, reg_rd_kind;
  logic [2:0] reg_wr_idx, reg_rd_idx;
  logic [7:0] reg_wr_data, reg_rd_data_q, pin_direction_control, port_latch, analog_select;
  logic [7:0] port_level_q, pin_in, pin_out_q, pin_oe_q, periph_in_q, periph_out;
  logic [7:0] periph_oe_req, periph_oe, v, d;
  int n_mismatch = 0;
  int checked = 0;
  pprl_top uut (.mclk, .nrst, .dev_rst_n, .reg_wr, .reg_wr_kind, .reg_wr_idx, .reg_wr_data,
    .reg_rd_kind, .reg_rd_idx, .reg_rd_data_q, .one_shot_lock_fuse, .sleep_mode,
    .selection_lock_flag_q, .pin_direction_control, .port_latch, .analog_select, .port_level_q,
    .pin_in, .pin_out_q, .pin_oe_q, .periph_in_q, .periph_out, .periph_oe_req, .periph_oe);
  pprl_far_model far (.mclk, .pin_in, .periph_out);
  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Verdict and end of run
  task finish_test;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // One write; strobe stays up for back-to-back writes
  task wr(input logic [1:0] k, input logic [2:0] i, input logic [7:0] dt);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_wr_kind <= k;
    reg_wr_idx <= i;
    reg_wr_data <= dt;
  endtask : wr
  task idle;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : idle
  task rd(input logic [1:0] k, input logic [2:0] i);
    @(posedge mclk);
    reg_rd_kind <= k;
    reg_rd_idx <= i;
    @(posedge mclk);
    #1 d = reg_rd_data_q;
  endtask : rd
  task lock_seq(input logic b);
    wr(2'h2, 3'h0, 8'h55);
    wr(2'h2, 3'h0, 8'haa);
    wr(2'h2, 3'h0, {7'h00, b});
    idle;
  endtask : lock_seq
  // Two inputs against one pin level
  task route_in(input int i, input int j, input int p);
    @(negedge mclk);
    v = pin_in;
    @(posedge mclk);
    #1 `CHK("in_route", v[p] & ~analog_select[p], periph_in_q[i])
    `CHK("in_route", v[p] & ~analog_select[p], periph_in_q[j])
    `CHK("port_level", v, port_level_q)
  endtask : route_in
  task t_defaults;
    for (int i = 0; i < 8; i++) begin
      rd(2'h0, 3'(i));
      `CHK("in_sel", 8'(i), d)
      rd(2'h1, 3'(i));
      `CHK("out_sel", 8'h00, d)
      route_in(i, i, i);
    end
  endtask : t_defaults
  task t_route;
    @(posedge mclk);
    analog_select <= 8'h00;
    wr(2'h0, 3'h2, 8'h05);
    wr(2'h0, 3'h6, 8'h05);
    wr(2'h1, 3'h3, 8'h02);
    wr(2'h1, 3'h4, 8'h00);
    wr(2'h0, 3'h1, 8'h03);
    idle;
    route_in(2, 6, 5);
    route_in(1, 1, 3);
    @(negedge mclk);
    v = periph_out;
    @(posedge mclk);
    #1 `CHK("pin_out", v[1], pin_out_q[3])
    `CHK("pin_out", port_latch[4], pin_out_q[4])
    `CHK("pin_oe", ~pin_direction_control[3], pin_oe_q[3])
    @(posedge mclk);
    periph_oe_req <= 8'h02;
    @(posedge mclk);
    #1 `CHK("pin_oe", 1'b0, pin_oe_q[3])
    @(posedge mclk);
    periph_oe_req <= 8'h00;
    sleep_mode <= 1'b1;
    rd(2'h0, 3'h2);
    `CHK("sleep_sel", 8'h05, d)
    rd(2'h3, 3'h0);
    `CHK("spare_rd", 8'h00, d)
    @(posedge mclk);
    sleep_mode <= 1'b0;
  endtask : t_route
  task t_lock;
    lock_seq(1'b1);
    rd(2'h2, 3'h0);
    `CHK("lock", 8'h01, d)
    `CHK("lock_flag", 1'b1, selection_lock_flag_q)
    wr(2'h0, 3'h2, 8'h03);
    idle;
    rd(2'h0, 3'h2);
    `CHK("locked_sel", 8'h05, d)
    wr(2'h2, 3'h0, 8'h55);
    wr(2'h1, 3'h0, 8'h01);
    wr(2'h2, 3'h0, 8'haa);
    wr(2'h2, 3'h0, 8'h00);
    idle;
    rd(2'h2, 3'h0);
    `CHK("lock", 8'h01, d)
    lock_seq(1'b0);
    wr(2'h0, 3'h2, 8'h03);
    idle;
    rd(2'h0, 3'h2);
    `CHK("sel", 8'h03, d)
  endtask : t_lock
  task t_fuse;
    @(posedge mclk);
    one_shot_lock_fuse <= 1'b1;
    dev_rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    dev_rst_n <= 1'b1;
    rd(2'h0, 3'h2);
    `CHK("kept_sel", 8'h03, d)
    lock_seq(1'b1);
    rd(2'h2, 3'h0);
    `CHK("lock", 8'h01, d)
    lock_seq(1'b0);
    rd(2'h2, 3'h0);
    `CHK("fuse_lock", 8'h01, d)
    lock_seq(1'b1);
    lock_seq(1'b0);
    lock_seq(1'b1);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd(2'h0, 3'h2);
    `CHK("por_sel", 8'h02, d)
  endtask : t_fuse
  // Main sequence
  initial begin
    {nrst, reg_wr, one_shot_lock_fuse, sleep_mode, reg_wr_data, periph_oe_req, periph_oe} = '0;
    {reg_wr_kind, reg_wr_idx, reg_rd_kind, reg_rd_idx} = '0;
    dev_rst_n = 1'b1;
    pin_direction_control = 8'hf0;
    port_latch = 8'h5a;
    analog_select = 8'h0f;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    t_defaults;
    t_route;
    t_lock;
    t_fuse;
    finish_test;
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    finish_test;
  end
endmodule : test_pprl_top
`default_nettype wire
